// file: src/call_return_stack.sv
/*
 * Eight-level return-address stack with its pointer, the global interrupt
 * enable, the entry bytes and stack error events, all reachable over APB.
 * Register map, by word index (byte address is four times the index):
 *   0xdf        pointer in bits 2..0, interrupt enable in bit 7
 *   0xe0        event status, write one to clear: bit 0 overflow, bit 1 underflow
 *   0xe1        event mask, same layout as the status
 *   0xe2        fill level 0..8, read only
 *   0xf0..0xff  entry bytes: even index low byte, odd index high byte
 * Every access takes one wait state; unmapped or unaligned addresses answer
 * with pslverr and are otherwise ignored.
 * Assumes the sequencer drives one request per cycle on ref_clk, and that a
 * push and a pop in one request stand for a call followed by its return.
 */
// The implementer's own choice: register access over APB.
// Functional notes
// - A three-bit stack pointer sits in bits 2..0 of the pointer register at index 0xDF and selects the entry.
// - Each entry holds a 13-bit program counter split into a high and a low byte.
// - A push decrements the pointer and a pop increments it.
// - The program counter is pushed on a call and on interrupt entry.
// - Pops return values in last-in first-out order.
// - Return from interrupt and return from call both pop the stack.
// - A pop loads the popped entry into the program counter and the pointer then marks the next free slot.
// - Level 0 is pointer all ones, pushes fill entries 0 to 7 in order, level 8 has the pointer back at all ones.
// - After a push the pointer marks the next free slot and the entry holds the return opcode address.
// - Bit 7 of the pointer register is a read/write global interrupt enable.
// - The pointer and all entry bytes are registers, the entry bytes at indices 0xF0 to 0xFF.
// - The high byte holds pc bits 12..8 in bits 4..0 with bits 7..5 unused, the low byte pc bits 7..0.
// - The stack has exactly eight levels shared by calls and interrupts.
`timescale 1ns/100ps
module call_return_stack #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Sequencer side
	input  wire stack_pkg::stack_req_s req,
	output stack_pkg::stack_ret_s     ret,
	output logic                      global_irq_enable,
	output logic [2:0]                stack_pointer,
	output logic                      irq
);

	// Storage
	logic [stack_pkg::PC_W-1:0]    entry [stack_pkg::DEPTH];
	logic [stack_pkg::LEVEL_W-1:0] level;
	logic [stack_pkg::EVT_W-1:0]   evt_status;
	logic [stack_pkg::EVT_W-1:0]   evt_mask;
	logic                          ack;

	// Bus decode
	logic [stack_pkg::IDX_W-1:0]   idx;
	logic                          aligned;
	logic                          hit_ptr;
	logic                          hit_entry;
	logic                          hit_status;
	logic                          hit_mask;
	logic                          hit_level;
	logic                          mapped;
	logic                          bus_done;
	logic                          sw_wr;
	logic [stack_pkg::PTR_W-1:0]   entry_sel;
	logic                          entry_hi;

	// Stack datapath
	logic                          do_push;
	logic                          do_pop;
	logic                          both;
	logic [stack_pkg::PTR_W-1:0]   push_slot;
	logic [stack_pkg::PTR_W-1:0]   pop_ptr;
	logic [stack_pkg::PTR_W-1:0]   pop_slot;
	logic [stack_pkg::EVT_W-1:0]   evt_set;
	logic [stack_pkg::EVT_W-1:0]   evt_clr;
	logic [31:0]                   next_prdata;
	logic                          next_slverr;

	// Word index from the byte address; unaligned addresses map to nothing
	assign idx        = paddr[stack_pkg::IDX_W+1:2];
	assign aligned    = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:stack_pkg::IDX_W+2] == '0);
	assign hit_ptr    = aligned && (idx == stack_pkg::IDX_POINTER);
	assign hit_entry  = aligned && (idx >= stack_pkg::IDX_ENTRY_FIRST) && (idx <= stack_pkg::IDX_ENTRY_LAST);
	assign hit_status = aligned && (idx == stack_pkg::IDX_EVT_STATUS);
	assign hit_mask   = aligned && (idx == stack_pkg::IDX_EVT_MASK);
	assign hit_level  = aligned && (idx == stack_pkg::IDX_LEVEL);
	assign mapped     = hit_ptr || hit_entry || hit_status || hit_mask || hit_level;

	// Even index is the low byte of entry n, odd index its high byte
	assign entry_sel  = idx[3:1];
	assign entry_hi   = idx[0];

	// One wait state: the first access cycle registers read data, the second completes
	assign pready     = psel && penable && ack;
	assign bus_done   = psel && penable && ack;
	assign sw_wr      = bus_done && pwrite && !pslverr;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= psel && penable && !ack;
		end
	end

	// Sequencer requests; a pop is either return kind
	assign do_push   = req.push;
	assign do_pop    = req.pop;
	assign both      = do_push && do_pop;
	// Entry index is the inverted pointer: pointer 111 before a push fills entry 0
	assign push_slot = ~stack_pointer;
	assign pop_ptr   = stack_pointer + 3'h1;
	assign pop_slot  = ~pop_ptr;

	// Pointer: hardware moves win over a software write in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stack_pointer <= stack_pkg::RST_POINTER;
		end else if (both) begin
			stack_pointer <= stack_pointer;
		end else if (do_push) begin
			stack_pointer <= stack_pointer - 3'h1;
		end else if (do_pop) begin
			stack_pointer <= pop_ptr;
		end else if (sw_wr && hit_ptr) begin
			stack_pointer <= pwdata[stack_pkg::POS_PTR_LO +: stack_pkg::PTR_W];
		end
	end

	// Interrupt enable shares the pointer register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			global_irq_enable <= stack_pkg::RST_IRQ_EN;
		end else if (sw_wr && hit_ptr) begin
			global_irq_enable <= pwdata[stack_pkg::POS_IRQ_EN];
		end
	end

	// Fill level tells level 0 from level 8, which share a pointer value
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			level <= stack_pkg::RST_LEVEL;
		end else if (both) begin
			level <= level;
		end else if (do_push) begin
			level <= (level == stack_pkg::FULL_LEVEL) ? level : level + 4'h1;
		end else if (do_pop) begin
			level <= (level == stack_pkg::RST_LEVEL) ? level : level - 4'h1;
		end else if (sw_wr && hit_ptr) begin
			level <= 4'(stack_pkg::RST_POINTER - pwdata[stack_pkg::POS_PTR_LO +: stack_pkg::PTR_W]);
		end
	end

	// Entries: a push writes the top slot; software may patch any byte
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < stack_pkg::DEPTH; i++) begin
				entry[i] <= stack_pkg::RST_ENTRY;
			end
		end else if (do_push) begin
			entry[push_slot] <= req.pc;
		end else if (sw_wr && hit_entry) begin
			if (entry_hi) begin
				entry[entry_sel][12:8] <= pwdata[stack_pkg::HIGH_BITS-1:0];
			end else begin
				entry[entry_sel][7:0] <= pwdata[7:0];
			end
		end
	end

	// Restored pc; a same-cycle push and pop hands back the pc just pushed
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ret <= '0;
		end else begin
			ret.valid    <= do_pop;
			ret.from_irq <= do_pop && req.from_irq;
			if (both) begin
				ret.pc <= req.pc;
			end else if (do_pop) begin
				ret.pc <= entry[pop_slot];
			end
		end
	end

	// Stack error events; a push at level 8 still wraps as the hardware does
	assign evt_set[stack_pkg::EVT_OVERFLOW]  = do_push && !do_pop && (level == stack_pkg::FULL_LEVEL);
	assign evt_set[stack_pkg::EVT_UNDERFLOW] = do_pop && !do_push && (level == stack_pkg::RST_LEVEL);
	assign evt_clr = (sw_wr && hit_status) ? pwdata[stack_pkg::EVT_W-1:0] : '0;

	generate
		for (genvar g = 0; g < stack_pkg::EVT_W; g++) begin : gen_evt
			sticky_flag u_flag (
				.ref_clk (ref_clk),
				.arst_n  (arst_n),
				.set     (evt_set[g]),
				.clear   (evt_clr[g]),
				.flag    (evt_status[g])
			);
		end
	endgenerate

	// Event mask
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_mask <= stack_pkg::RST_EVT_MASK;
		end else if (sw_wr && hit_mask) begin
			evt_mask <= pwdata[stack_pkg::EVT_W-1:0];
		end
	end

	// Level output so a stuck flag cannot glitch the line
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_status & evt_mask);
		end
	end

	// Read data mux; reserved bits read zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_slverr = !mapped;
		if (hit_ptr) begin
			next_prdata[stack_pkg::POS_IRQ_EN] = global_irq_enable;
			next_prdata[stack_pkg::POS_PTR_LO +: stack_pkg::PTR_W] = stack_pointer;
		end else if (hit_entry) begin
			if (entry_hi) begin
				next_prdata[stack_pkg::HIGH_BITS-1:0] = entry[entry_sel][12:8];
			end else begin
				next_prdata[7:0] = entry[entry_sel][7:0];
			end
		end else if (hit_status) begin
			next_prdata[stack_pkg::EVT_W-1:0] = evt_status;
		end else if (hit_mask) begin
			next_prdata[stack_pkg::EVT_W-1:0] = evt_mask;
		end else if (hit_level) begin
			next_prdata[stack_pkg::LEVEL_W-1:0] = level;
		end
	end

	// Read data registered in the first access cycle, held for the completing one
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !ack) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
		end
	end

	// Error flag has the same timing; it drops once the slave is deselected
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else if (psel && penable && !ack) begin
			pslverr <= next_slverr;
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end

endmodule : call_return_stack

// file: src/stack_pkg.sv
/*
 * Constants, register map and carrier types of the return-address stack.
 * Assumes a 32-bit APB slave port where each register index is one word.
 */
package stack_pkg;

	// Geometry of the stack
	localparam int unsigned PC_W     = 13;
	localparam int unsigned PTR_W    = 3;
	localparam int unsigned DEPTH    = 8;
	localparam int unsigned LEVEL_W  = 4;
	localparam int unsigned IDX_W    = 8;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_POINTER     = 8'hdf;
	localparam logic [7:0] IDX_ENTRY_FIRST = 8'hf0;
	localparam logic [7:0] IDX_ENTRY_LAST  = 8'hff;
	localparam logic [7:0] IDX_EVT_STATUS  = 8'he0;
	localparam logic [7:0] IDX_EVT_MASK    = 8'he1;
	localparam logic [7:0] IDX_LEVEL       = 8'he2;

	// Field positions in the pointer register
	localparam int unsigned POS_IRQ_EN = 7;
	localparam int unsigned POS_PTR_LO = 0;

	// Width of the pc field in the high entry byte
	localparam int unsigned HIGH_BITS = 5;

	// Values after reset, and the fill level of a full stack
	localparam logic [2:0]  RST_POINTER = 3'h7;
	localparam logic        RST_IRQ_EN  = 1'b0;
	localparam logic [12:0] RST_ENTRY   = 13'h0000;
	localparam logic [3:0]  RST_LEVEL   = 4'h0;
	localparam logic [3:0]  FULL_LEVEL  = 4'h8;

	// Event flags
	localparam int unsigned EVT_W         = 2;
	localparam int unsigned EVT_OVERFLOW  = 0;
	localparam int unsigned EVT_UNDERFLOW = 1;
	localparam logic [1:0]  RST_EVT_MASK  = 2'h0;

	// Request from the instruction sequencer, one cycle per instruction
	typedef struct packed {
		logic            push;
		logic            pop;
		logic            from_irq;
		logic [12:0]     pc;
	} stack_req_s;

	// Restored program counter handed back to the sequencer
	typedef struct packed {
		logic            valid;
		logic            from_irq;
		logic [12:0]     pc;
	} stack_ret_s;

endpackage : stack_pkg

// file: src/sticky_flag.sv
/*
 * One sticky event flag: set by a hardware pulse, cleared by a one written
 * from software. Assumes both inputs are on ref_clk.
 */
`timescale 1ns/100ps
module sticky_flag (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);

	// A set in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end

endmodule : sticky_flag

// file: verification/call_return_stack_tb.sv
/*
 * Self-checking bench of the return-address stack over APB and the sequencer.
 * Assumes one wait state or more on APB and returns one cycle after a pop.
 */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, e, s); end end
module call_return_stack_tb;
	logic                  ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, global_irq_enable, irq;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata;
	logic [2:0]            stack_pointer;
	stack_pkg::stack_req_s req;
	stack_pkg::stack_ret_s ret;
	logic [12:0]           pcs[8];
	logic [13:0]           exp_pc[$];
	logic [32:0]           exp_rd[$];
	int                    num_errors = 0, tests_run = 0, i;

	call_return_stack u_call_return_stack (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req(req), .ret(ret),
		.global_irq_enable(global_irq_enable), .stack_pointer(stack_pointer), .irq(irq));
	seq_model u_seq_model (.ref_clk(ref_clk), .req(req));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// One APB transfer; a read notes {pslverr, prdata} expected
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [32:0] ex);
		int n = 0;
		@(posedge ref_clk);
		if (!wr) exp_rd.push_back(ex);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Request stands until the rising edge that samples pready high
		do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin num_errors++; print_verdict(); end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Watches outputs and takes the oldest note once per result; a result with no note mismatches
	always @(negedge ref_clk) begin : watch
		logic [32:0] rd_note;
		logic [13:0] ret_note;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			rd_note = (exp_rd.size() > 0) ? exp_rd.pop_front() : 'x;
			`CHK("rd", rd_note, {pslverr, prdata})
		end
		if (ret.valid === 1'b1) begin
			ret_note = (exp_pc.size() > 0) ? exp_pc.pop_front() : 'x;
			`CHK("ret", ret_note, {ret.from_irq, ret.pc})
		end
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'h0f78e22b));
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		`CHK("ptr", 3'h7, stack_pointer)
		apb(0, 8'hdf, 0, 33'h7);
		apb(1, 8'hdf, 32'h87, 0);
		apb(0, 8'hdf, 0, 33'h87);
		apb(1, 8'he1, 32'h2, 0);
		apb(0, 8'h00, 0, {1'b1, 32'h0});
		for (i = 0; i < 8; i++) begin pcs[i] = 13'($urandom); u_seq_model.op(1, 0, i[0], pcs[i]); end
		u_seq_model.idle();
		@(negedge ref_clk);
		`CHK("ptr8", 3'h7, stack_pointer)
		apb(0, 8'he2, 0, 33'h8);
		for (i = 0; i < 8; i++) begin
			apb(0, 8'(8'hf0 + 2 * i), 0, {25'h0, pcs[i][7:0]});
			apb(0, 8'(8'hf1 + 2 * i), 0, {28'h0, pcs[i][12:8]});
		end
		for (i = 7; i >= 0; i--) begin exp_pc.push_back({i[0], pcs[i]}); u_seq_model.op(0, 1, i[0], '0); end
		exp_pc.push_back({1'b0, pcs[7]});
		u_seq_model.op(0, 1, 0, '0);
		u_seq_model.idle();
		repeat (2) @(negedge ref_clk);
		`CHK("irq", 1'b1, irq)
		apb(0, 8'he0, 0, 33'h2);
		apb(1, 8'he0, 32'h2, 0);
		repeat (2) @(negedge ref_clk);
		`CHK("irq0", 1'b0, irq)
		apb(1, 8'hdf, 32'h07, 0);
		for (i = 0; i < 9; i++) u_seq_model.op(1, 0, 0, 13'($urandom));
		exp_pc.push_back({1'b0, 13'h1abc});
		u_seq_model.op(1, 1, 0, 13'h1abc);
		exp_pc.push_back({1'b1, 13'h0abc});
		u_seq_model.op(1, 0, 0, 13'h0abc);
		u_seq_model.op(0, 1, 1, '0);
		u_seq_model.idle();
		repeat (2) @(negedge ref_clk);
		`CHK("ptr6", 3'h6, stack_pointer)
		`CHK("masked", 1'b0, irq)
		apb(0, 8'he0, 0, 33'h1);
		// Software patch of a high entry byte: bits above the pc field read zero
		apb(1, 8'hf3, 32'hff, 0);
		apb(0, 8'hf3, 0, 33'h1f);
		// Level register ignores writes; one pop from a saturated level 8 left it at 7
		apb(1, 8'he2, 32'h5, 0);
		apb(0, 8'he2, 0, 33'h7);
		// Second reset in mid-run with the enable set and entries in use
		apb(1, 8'hdf, 32'h85, 0);
		@(negedge ref_clk);
		`CHK("irq_en", 1'b1, global_irq_enable)
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		`CHK("ptr_rst", 3'h7, stack_pointer)
		`CHK("irq_en_rst", 1'b0, global_irq_enable)
		apb(0, 8'hdf, 0, 33'h7);
		apb(0, 8'hf3, 0, 33'h0);
		apb(0, 8'he0, 0, 33'h0);
		`CHK("left", 0, exp_pc.size() + exp_rd.size())
		print_verdict();
	end
endmodule : call_return_stack_tb

// file: verification/seq_model.sv
/*
 * Instruction sequencer model: one call, interrupt entry or return a cycle, or a call with its return.
 * Assumes the caller sequences requests on ref_clk.
 */
`timescale 1ns/100ps
module seq_model (
	input  wire logic             ref_clk,
	output stack_pkg::stack_req_s req
);
	initial req = '0;

	// Request stands from this edge and is taken at the next one
	task automatic op(input logic ps, input logic pp, input logic fi, input logic [12:0] pc);
		@(posedge ref_clk);
		req <= '{ps, pp, fi, pc};
	endtask : op

	// Released: stale pc is inverted so it never looks valid
	task automatic idle();
		@(posedge ref_clk);
		req <= '{1'b0, 1'b0, 1'b0, ~req.pc};
	endtask : idle
endmodule : seq_model

// file: verification/stack_chk_sva.sv
/*
 * Port checker of the return-address stack.
 * Assumes it is bound to every call_return_stack instance on ref_clk.
 */
`timescale 1ns/100ps
module stack_chk #(
	parameter int unsigned ADDR_W = 12
) (
	input wire logic                  ref_clk,
	input wire logic                  arst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_W-1:0]     paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire stack_pkg::stack_req_s req,
	input wire stack_pkg::stack_ret_s ret,
	input wire logic                  global_irq_enable,
	input wire logic [2:0]            stack_pointer,
	input wire logic                  irq
);
	logic ptr_wr;

	// Completed software write of the pointer register
	assign ptr_wr = psel && penable && pready && pwrite && paddr == ADDR_W'({stack_pkg::IDX_POINTER, 2'b00});

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_push_lowers_ptr: assert property (
		req.push && !req.pop |=> stack_pointer == $past(stack_pointer) - 3'h1) else $error("push kept pointer");
	a_pop_raises_ptr: assert property (
		req.pop && !req.push |=> stack_pointer == $past(stack_pointer) + 3'h1) else $error("pop kept pointer");
	a_pop_returns: assert property (
		req.pop |=> ret.valid && ret.from_irq == $past(req.from_irq)) else $error("pop gave no return");
	a_no_ret_idle: assert property (
		!req.pop |=> !ret.valid) else $error("return without pop");
	a_same_cycle: assert property (
		req.push && req.pop |=> stack_pointer == $past(stack_pointer) && ret.pc == $past(req.pc))
		else $error("push and pop mixed up");
	a_lifo_pair: assert property (
		(req.push && !req.pop) ##1 (req.pop && !req.push) |=> ret.pc == $past(req.pc, 2))
		else $error("pop missed last push");
	a_ptr_written: assert property (
		ptr_wr && !req.push && !req.pop |=> stack_pointer == $past(pwdata[2:0])
		&& global_irq_enable == $past(pwdata[7])) else $error("pointer write lost");
	a_irq_en_hold: assert property (
		!ptr_wr |=> $stable(global_irq_enable)) else $error("irq enable moved");
	a_ptr_hold: assert property (
		!req.push && !req.pop && !ptr_wr |=> $stable(stack_pointer)) else $error("pointer moved");
	a_ready_pulse: assert property (
		pready |=> !pready) else $error("ready held two cycles");
	a_err_idle: assert property (
		!psel |=> !pslverr) else $error("error flag without transfer");

	c_both: cover property (req.push && req.pop);
	c_pop_empty: cover property (req.pop && stack_pointer == 3'h7);
	c_ptr_wr: cover property (ptr_wr);
endmodule : stack_chk

bind call_return_stack stack_chk #(.ADDR_W(ADDR_W)) u_stack_chk (.ref_clk(ref_clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .req(req), .ret(ret), .global_irq_enable(global_irq_enable),
	.stack_pointer(stack_pointer), .irq(irq));
